/* hdl/flash_protect_seq.sv */
// What this block does
// - chip erase is bytes C7,94,80,9A with no address
// - bytes after the fourth are ignored; erase starts at chip select rise
// - chip erase is self-timed and status shows busy throughout
// - chip erase spares protected and locked sectors
// - write-protect asserted during erase takes effect once erase ends
// - page program opcode 82 or 85 picks buffer, then three address bytes
// - 528-byte pages: one spare bit, 13 page bits, 10 byte bits
// - 512-byte pages: two spare bits, 13 page bits, 9 byte bits
// - data bytes fill the buffer at rising positions, wrapping to zero
// - chip select rise starts page erase plus program; busy until done
// - 3D,2A,7F,A9 enables protection of sectors marked in the register
// - protect commands take effect only at chip select rise
// - 3D,2A,7F,9A disables software protection at chip select rise
// - disable command is ignored while write-protect is asserted
// - software protection is off after reset
// - write-protect asserted blocks marked sectors and protection register writes
// - asserting write-protect enables protection within WP_FILT_P + 5 clocks, one clock past the enable delay by default
// - releasing write-protect drops protection unless software enabled it
// - software enable survives write-protect release until a disable command
// - status shows protection on, by command or pin
// - write-protect input is filtered against glitches
// - guarded sectors come only from the protection register
// - one byte per sector; FF protected, 00 unprotected; sector 0 split
module flash_protect_seq #(
  parameter int CE_CYCLES_P = flash_seq_pkg::CE_CYCLES,
  parameter int EP_CYCLES_P = flash_seq_pkg::EP_CYCLES,
  parameter int WP_FILT_P   = flash_seq_pkg::WP_FILTER_CYCLES,
  parameter bit PAGE_512    = 1'b0
) (
  input  wire logic         MCLK_IN,
  input  wire logic         NRST_IN,
  input  wire logic         SCK_IN,
  input  wire logic         CS_N_IN,
  input  wire logic         SI_IN,
  input  wire logic         WP_N_IN,
  input  wire logic         PROT_WE_IN,
  input  wire logic [5:0]   PROT_IDX_IN,
  input  wire logic [7:0]   PROT_DATA_IN,
  input  wire logic [64:0]  LOCKED_IN,
  input  wire logic [9:0]   BUF_RD_ADDR_IN,
  output logic              READY_BUSY_OUT,
  output logic              STATUS_BUSY_OUT,
  output logic              STATUS_PROTECT_OUT,
  output flash_seq_pkg::array_op_t ARRAY_OP_OUT,
  output logic [12:0]       ARRAY_PAGE_OUT,
  output logic              ARRAY_BUF_SEL_OUT,
  output logic [64:0]       ERASE_MASK_OUT,
  output logic [7:0]        BUF_RD_DATA_OUT
);
  import flash_seq_pkg::*;

  localparam int          PB       = PAGE_512 ? PAGE_BYTES_512 : PAGE_BYTES_528;
  localparam logic [9:0]  BUF_LAST = 10'(PB - 1);
  localparam logic [10:0] BUF_OFS  = 11'(PB);

  if (CE_CYCLES_P < 1 || EP_CYCLES_P < 1 || WP_FILT_P < 1 || WP_FILT_P > 255) begin : g_chk
    $error("flash_protect_seq: timing parameter out of range");
  end

  // link domain state
  typedef struct packed {
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [6:0]  shift;
    logic [7:0]  op;
    logic        match;
    logic [15:0] addr;
    cmd_t        cmd;
    logic [12:0] page;
    logic        sel;
    logic [9:0]  ptr;
  } link_t;

  // core domain state
  typedef struct packed {
    logic [2:0]  wp_sync;
    logic        wp_stable;
    logic [7:0]  filt_cnt;
    logic        wp_on;
    logic [2:0]  cs_sync;
    logic        cs_stable;
    logic        sw_en;
    logic        hw_prot;
    logic        prot;
    logic        busy;
    logic        ready;
    array_op_t   op;
    logic [31:0] timer;
    logic [12:0] page;
    logic        sel;
    logic [64:0] mask;
    logic [7:0]  rd_data;
  } core_t;

  link_t       l_r;
  link_t       l_nxt;
  core_t       c_r;
  core_t       c_nxt;
  logic        frame_on_r;
  logic        frame_rst;
  logic        buf_we;
  logic [10:0] buf_wa;
  logic [7:0]  buf_wd;
  logic [7:0]  buf_mem [2*PB];
  logic [7:0]  prot_mem [NUM_SECTORS];
  logic [64:0] marked;

  // frame marker: cleared whenever chip select is high
  assign frame_rst = CS_N_IN | ~NRST_IN;

  always_ff @(posedge SCK_IN or posedge frame_rst) begin
    if (frame_rst) begin
      frame_on_r <= 1'b0;
    end else begin
      frame_on_r <= 1'b1;
    end
  end

  // serial command decode
  always_comb begin
    logic [2:0]  bc;
    logic [2:0]  yc;
    logic [7:0]  byte_v;
    logic [23:0] full;
    bc     = frame_on_r ? l_r.bit_cnt : 3'h0;
    yc     = frame_on_r ? l_r.byte_cnt : 3'h0;
    byte_v = {l_r.shift, SI_IN};
    full   = {l_r.addr, byte_v};
    l_nxt  = l_r;
    buf_we = 1'b0;
    buf_wa = l_r.sel ? 11'({1'b0, l_r.ptr} + BUF_OFS) : {1'b0, l_r.ptr};
    buf_wd = byte_v;
    if (!frame_on_r) begin
      l_nxt.cmd   = CMD_NONE;
      l_nxt.match = 1'b1;
    end
    l_nxt.shift   = {l_r.shift[5:0], SI_IN};
    l_nxt.bit_cnt = 3'(bc + 3'h1);
    l_nxt.byte_cnt = yc;
    if (bc == BIT_IDX_LAST) begin
      l_nxt.byte_cnt = (yc == BYTE_IDX_DATA) ? yc : 3'(yc + 3'h1);
      case (yc)
        3'h0: begin
          l_nxt.op = byte_v;
        end
        3'h1: begin
          l_nxt.addr[15:8] = byte_v;
          if (l_r.op == OP_CE0) begin
            l_nxt.match = l_nxt.match & (byte_v == OP_CE1);
          end else if (l_r.op == OP_PROT0) begin
            l_nxt.match = l_nxt.match & (byte_v == OP_PROT1);
          end
        end
        3'h2: begin
          l_nxt.addr[7:0] = byte_v;
          if (l_r.op == OP_CE0) begin
            l_nxt.match = l_r.match & (byte_v == OP_CE2);
          end else if (l_r.op == OP_PROT0) begin
            l_nxt.match = l_r.match & (byte_v == OP_PROT2);
          end
        end
        BYTE_IDX_LAST: begin
          if (l_r.op == OP_CE0 && l_r.match && byte_v == OP_CE3) begin
            l_nxt.cmd = CMD_CHIP_ERASE;
          end else if (l_r.op == OP_PROT0 && l_r.match && byte_v == OP_PROT_EN) begin
            l_nxt.cmd = CMD_PROT_EN;
          end else if (l_r.op == OP_PROT0 && l_r.match && byte_v == OP_PROT_DIS) begin
            l_nxt.cmd = CMD_PROT_DIS;
          end else if (l_r.op == OP_PGM_B1 || l_r.op == OP_PGM_B2) begin
            l_nxt.cmd = CMD_PAGE_PROG;
            l_nxt.sel = (l_r.op == OP_PGM_B2);
            if (PAGE_512) begin
              l_nxt.page = full[A512_PAGE_LSB +: PAGE_BITS];
              l_nxt.ptr  = {1'b0, full[A512_PAGE_LSB-1:0]};
            end else begin
              l_nxt.page = full[A528_PAGE_LSB +: PAGE_BITS];
              l_nxt.ptr  = full[BYTE_BITS-1:0];
            end
          end
        end
        BYTE_IDX_DATA: begin
          // later bytes of other commands fall here and are dropped
          if (l_r.cmd == CMD_PAGE_PROG) begin
            buf_we    = (l_r.ptr <= BUF_LAST);
            l_nxt.ptr = (l_r.ptr >= BUF_LAST) ? 10'h000 : 10'(l_r.ptr + 10'h001);
          end
        end
        default: begin
          l_nxt.byte_cnt = BYTE_IDX_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge SCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      l_r <= '{cmd: CMD_NONE, match: 1'b1, default: '0};
    end else begin
      l_r <= l_nxt;
    end
  end

  // page buffers, written from the link side
  always_ff @(posedge SCK_IN) begin
    if (buf_we) begin
      buf_mem[buf_wa] <= buf_wd;
    end
  end

  // protection register store; read-only while write-protect holds
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      for (int i = 0; i < NUM_SECTORS; i++) begin
        prot_mem[i] <= PROT_BYTE_RST;
      end
    end else if (PROT_WE_IN && !c_r.wp_on) begin
      prot_mem[PROT_IDX_IN] <= PROT_DATA_IN;
    end
  end

  // guard bits: 0a, 0b, then sectors 1 to 63
  for (genvar g = 0; g < NUM_SECTORS; g++) begin : g_mark
    if (g == 0) begin : g_s0
      assign marked[0] = &prot_mem[0][SEC0A_HI -: 2];
      assign marked[1] = &prot_mem[0][SEC0B_HI -: 2];
    end else begin : g_sn
      assign marked[g+1] = (prot_mem[g] == SEC_PROTECTED);
    end
  end

  // core sequencing
  always_comb begin
    logic [5:0] sec;
    logic [6:0] gidx;
    logic       cs_rise;
    logic [10:0] ra;
    sec   = l_r.page[PAGE_SEC_LSB +: 6];
    cs_rise = 1'b0;
    gidx  = (sec != 6'h00) ? 7'({1'b0, sec} + 7'h01) :
            ((l_r.page <= SEC0A_LAST_PG) ? 7'h00 : 7'h01);
    ra    = c_r.sel ? 11'({1'b0, BUF_RD_ADDR_IN} + BUF_OFS) : {1'b0, BUF_RD_ADDR_IN};
    c_nxt = c_r;
    c_nxt.wp_sync = {c_r.wp_sync[1:0], WP_N_IN};
    c_nxt.cs_sync = {c_r.cs_sync[1:0], CS_N_IN};
    if (c_r.wp_sync[1] == c_r.wp_sync[2]) begin
      c_nxt.wp_stable = ~c_r.wp_sync[2];
    end
    if (c_r.wp_stable == c_r.wp_on) begin
      c_nxt.filt_cnt = 8'h00;
    end else if (c_r.filt_cnt >= 8'(WP_FILT_P - 1)) begin
      c_nxt.filt_cnt = 8'h00;
      c_nxt.wp_on    = c_r.wp_stable;
    end else begin
      c_nxt.filt_cnt = 8'(c_r.filt_cnt + 8'h01);
    end
    if (c_r.cs_sync[1] == c_r.cs_sync[2]) begin
      c_nxt.cs_stable = c_r.cs_sync[2];
    end
    cs_rise = c_nxt.cs_stable & ~c_r.cs_stable;
    if (!c_r.busy) begin
      c_nxt.hw_prot = c_r.wp_on;
    end
    if (c_r.busy) begin
      if (c_r.timer == 32'h0) begin
        c_nxt.busy = 1'b0;
        c_nxt.op   = ARR_IDLE;
        c_nxt.mask = '0;
      end else begin
        c_nxt.timer = 32'(c_r.timer - 32'h1);
      end
    end else if (cs_rise) begin
      case (l_r.cmd)
        CMD_CHIP_ERASE: begin
          c_nxt.busy  = 1'b1;
          c_nxt.op    = ARR_CHIP_ERASE;
          c_nxt.timer = 32'(CE_CYCLES_P - 1);
          c_nxt.mask  = ~LOCKED_IN & ~(c_r.prot ? marked : 65'h0);
        end
        CMD_PAGE_PROG: begin
          if (!(c_r.prot && marked[gidx])) begin
            c_nxt.busy  = 1'b1;
            c_nxt.op    = ARR_PAGE_PROG;
            c_nxt.timer = 32'(EP_CYCLES_P - 1);
            c_nxt.page  = l_r.page;
            c_nxt.sel   = l_r.sel;
          end
        end
        CMD_PROT_EN: begin
          c_nxt.sw_en = 1'b1;
        end
        CMD_PROT_DIS: begin
          if (!c_r.wp_on && !c_r.hw_prot) begin
            c_nxt.sw_en = 1'b0;
          end
        end
        default: begin
          c_nxt.sw_en = c_r.sw_en;
        end
      endcase
    end
    c_nxt.prot    = c_nxt.sw_en | c_nxt.hw_prot;
    c_nxt.ready   = ~c_nxt.busy;
    c_nxt.rd_data = (ra < 11'(2*PB)) ? buf_mem[ra] : 8'h00;
  end

  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      c_r <= '{wp_sync: 3'h7, cs_sync: 3'h7, cs_stable: 1'b1, ready: 1'b1,
               op: ARR_IDLE, default: '0};
    end else begin
      c_r <= c_nxt;
    end
  end

  assign READY_BUSY_OUT     = c_r.ready;
  assign STATUS_BUSY_OUT    = c_r.busy;
  assign STATUS_PROTECT_OUT = c_r.prot;
  assign ARRAY_OP_OUT       = c_r.op;
  assign ARRAY_PAGE_OUT     = c_r.page;
  assign ARRAY_BUF_SEL_OUT  = c_r.sel;
  assign ERASE_MASK_OUT     = c_r.mask;
  assign BUF_RD_DATA_OUT    = c_r.rd_data;

endmodule : flash_protect_seq

/* pkg/flash_seq_pkg.sv */
package flash_seq_pkg;

  // command bytes
  localparam logic [7:0] OP_CE0      = 8'hc7;
  localparam logic [7:0] OP_CE1      = 8'h94;
  localparam logic [7:0] OP_CE2      = 8'h80;
  localparam logic [7:0] OP_CE3      = 8'h9a;
  localparam logic [7:0] OP_PGM_B1   = 8'h82;
  localparam logic [7:0] OP_PGM_B2   = 8'h85;
  localparam logic [7:0] OP_PROT0    = 8'h3d;
  localparam logic [7:0] OP_PROT1    = 8'h2a;
  localparam logic [7:0] OP_PROT2    = 8'h7f;
  localparam logic [7:0] OP_PROT_EN  = 8'ha9;
  localparam logic [7:0] OP_PROT_DIS = 8'h9a;

  // protection register layout
  localparam int         NUM_SECTORS    = 64;
  localparam int         NUM_GUARDS     = 65;
  localparam logic [7:0] SEC_PROTECTED  = 8'hff;
  localparam logic [7:0] PROT_BYTE_RST  = 8'h00;
  localparam int         SEC0A_HI       = 7;
  localparam int         SEC0B_HI       = 5;
  localparam logic [12:0] SEC0A_LAST_PG = 13'h0007;
  localparam int         PAGE_SEC_LSB   = 7;

  // addressing
  localparam int         PAGE_BITS      = 13;
  localparam int         BYTE_BITS      = 10;
  localparam int         PAGE_BYTES_528 = 528;
  localparam int         PAGE_BYTES_512 = 512;
  localparam int         A528_PAGE_LSB  = 10;
  localparam int         A512_PAGE_LSB  = 9;
  localparam logic [2:0] BYTE_IDX_DATA  = 3'h4;
  localparam logic [2:0] BYTE_IDX_LAST  = 3'h3;
  localparam logic [2:0] BIT_IDX_LAST   = 3'h7;

  // timing
  localparam int MCLK_MHZ                   = 10;
  localparam int CHIP_ERASE_TIME_MS         = 64000;
  localparam int PAGE_ERASE_PROGRAM_TIME_MS = 40;
  localparam int PROTECT_ENABLE_DELAY_NS    = 1000;
  localparam int PROTECT_DISABLE_DELAY_NS   = 1000;
  localparam int WP_SYNC_LAT                = 4;
  localparam int CE_CYCLES = CHIP_ERASE_TIME_MS * MCLK_MHZ * 1000;
  localparam int EP_CYCLES = PAGE_ERASE_PROGRAM_TIME_MS * MCLK_MHZ * 1000;
  localparam int WP_DELAY_NS = (PROTECT_ENABLE_DELAY_NS < PROTECT_DISABLE_DELAY_NS) ?
                               PROTECT_ENABLE_DELAY_NS : PROTECT_DISABLE_DELAY_NS;
  localparam int WP_FILTER_CYCLES = (WP_DELAY_NS * MCLK_MHZ) / 1000 - WP_SYNC_LAT;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_CHIP_ERASE, CMD_PAGE_PROG, CMD_PROT_EN, CMD_PROT_DIS
  } cmd_t;

  typedef enum logic [1:0] {
    ARR_IDLE, ARR_CHIP_ERASE, ARR_PAGE_PROG
  } array_op_t;

endpackage : flash_seq_pkg

/* verif/flash_seq_props.sv */
module flash_seq_props
  import flash_seq_pkg::*;
#(
  parameter int CE_CYCLES_P = 50,
  parameter int EP_CYCLES_P = 20
) (
  input wire logic        MCLK_IN,
  input wire logic        NRST_IN,
  input wire logic        SCK_IN,
  input wire logic        CS_N_IN,
  input wire logic        SI_IN,
  input wire logic        WP_N_IN,
  input wire logic        PROT_WE_IN,
  input wire logic [5:0]  PROT_IDX_IN,
  input wire logic [7:0]  PROT_DATA_IN,
  input wire logic [64:0] LOCKED_IN,
  input wire logic [9:0]  BUF_RD_ADDR_IN,
  input wire logic        READY_BUSY_OUT,
  input wire logic        STATUS_BUSY_OUT,
  input wire logic        STATUS_PROTECT_OUT,
  input flash_seq_pkg::array_op_t ARRAY_OP_OUT,
  input wire logic [12:0] ARRAY_PAGE_OUT,
  input wire logic        ARRAY_BUF_SEL_OUT,
  input wire logic [64:0] ERASE_MASK_OUT,
  input wire logic [7:0]  BUF_RD_DATA_OUT
);
  import flash_seq_pkg::*;
  int unsigned busy_cnt_r;
  array_op_t   last_op_r;
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      busy_cnt_r <= 0;
      last_op_r  <= ARR_IDLE;
    end else begin
      busy_cnt_r <= STATUS_BUSY_OUT ? busy_cnt_r + 1 : 0;
      last_op_r  <= STATUS_BUSY_OUT ? ARRAY_OP_OUT : last_op_r;
    end
  end
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence pg_run;
    ARRAY_OP_OUT == ARR_PAGE_PROG ##1 ARRAY_OP_OUT == ARR_PAGE_PROG;
  endsequence
  sequence wp_held;
    (!WP_N_IN && !STATUS_BUSY_OUT) [*8];
  endsequence
  chk_ready_busy_pair: assert property (READY_BUSY_OUT == !STATUS_BUSY_OUT)
    else $error("ready pin disagrees with busy");
  chk_op_while_busy: assert property (STATUS_BUSY_OUT == (ARRAY_OP_OUT != ARR_IDLE))
    else $error("array op disagrees with busy");
  chk_busy_length: assert property ($fell(STATUS_BUSY_OUT) |->
    busy_cnt_r == ((last_op_r == ARR_CHIP_ERASE) ? CE_CYCLES_P : EP_CYCLES_P))
    else $error("busy length wrong");
  chk_start_after_cs: assert property ($rose(STATUS_BUSY_OUT) |-> $past(CS_N_IN, 3))
    else $error("operation started while selected");
  chk_mask_locked: assert property ((ERASE_MASK_OUT & LOCKED_IN) == 65'h0)
    else $error("locked sector in erase mask");
  chk_mask_idle: assert property (ARRAY_OP_OUT != ARR_CHIP_ERASE |-> ERASE_MASK_OUT == 65'h0)
    else $error("erase mask outside chip erase");
  chk_page_held: assert property (pg_run |-> $stable(ARRAY_PAGE_OUT) && $stable(ARRAY_BUF_SEL_OUT))
    else $error("page or buffer moved during program");
  chk_wp_enables: assert property (wp_held |-> ##[0:4] STATUS_PROTECT_OUT)
    else $error("pin did not enable protection");
  chk_wp_drop_hold: assert property ($fell(STATUS_PROTECT_OUT) |-> $past(WP_N_IN) && $past(WP_N_IN, 4))
    else $error("protection dropped with pin asserted");
  chk_reset_state: assert property (disable iff (1'b0)
    !NRST_IN |-> READY_BUSY_OUT && !STATUS_BUSY_OUT && !STATUS_PROTECT_OUT)
    else $error("wrong state in reset");
endmodule : flash_seq_props

bind flash_protect_seq flash_seq_props #(.CE_CYCLES_P(CE_CYCLES_P), .EP_CYCLES_P(EP_CYCLES_P))
  flash_seq_props_inst (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .SCK_IN(SCK_IN), .CS_N_IN(CS_N_IN),
  .SI_IN(SI_IN), .WP_N_IN(WP_N_IN), .PROT_WE_IN(PROT_WE_IN), .PROT_IDX_IN(PROT_IDX_IN),
  .PROT_DATA_IN(PROT_DATA_IN), .LOCKED_IN(LOCKED_IN), .BUF_RD_ADDR_IN(BUF_RD_ADDR_IN),
  .READY_BUSY_OUT(READY_BUSY_OUT), .STATUS_BUSY_OUT(STATUS_BUSY_OUT),
  .STATUS_PROTECT_OUT(STATUS_PROTECT_OUT), .ARRAY_OP_OUT(ARRAY_OP_OUT),
  .ARRAY_PAGE_OUT(ARRAY_PAGE_OUT), .ARRAY_BUF_SEL_OUT(ARRAY_BUF_SEL_OUT),
  .ERASE_MASK_OUT(ERASE_MASK_OUT), .BUF_RD_DATA_OUT(BUF_RD_DATA_OUT));

/* verif/serial_flash_erase_program_protect_tb.sv */
module serial_flash_erase_program_protect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import flash_seq_pkg::*;
  logic        mclk = 1'b0, rst_n = 1'b1, wp_n = 1'b1, prot_we = 1'b0;
  logic [5:0]  prot_idx = 6'h0;
  logic [7:0]  prot_data = 8'h0;
  logic [64:0] locked = 65'h400;
  logic [9:0]  rd_addr = 10'h0;
  logic        sck, cs_n, si, ready, busy, prot, sel;
  array_op_t   op;
  logic [12:0] page;
  logic [64:0] mask;
  logic [7:0]  rd_data;
  int          n_fail = 0, tests_run = 0, cyc = 0;
  localparam logic [7:0] OP_CE[4] = '{OP_CE0, OP_CE1, OP_CE2, OP_CE3};
  always #50 mclk = ~mclk;
  spi_host_model spi_host_model_inst (.sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  flash_protect_seq #(.CE_CYCLES_P(50), .EP_CYCLES_P(20), .WP_FILT_P(4), .PAGE_512(1'b0))
    flash_protect_seq_inst (.MCLK_IN(mclk), .NRST_IN(rst_n), .SCK_IN(sck), .CS_N_IN(cs_n),
    .SI_IN(si), .WP_N_IN(wp_n), .PROT_WE_IN(prot_we), .PROT_IDX_IN(prot_idx),
    .PROT_DATA_IN(prot_data), .LOCKED_IN(locked), .BUF_RD_ADDR_IN(rd_addr),
    .READY_BUSY_OUT(ready), .STATUS_BUSY_OUT(busy), .STATUS_PROTECT_OUT(prot),
    .ARRAY_OP_OUT(op), .ARRAY_PAGE_OUT(page), .ARRAY_BUF_SEL_OUT(sel),
    .ERASE_MASK_OUT(mask), .BUF_RD_DATA_OUT(rd_data));
  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [64:0] got, input logic [64:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 200 && busy !== v; i++) @(posedge mclk);
    #1 chk(busy, v, "busy level");
  endtask : wait_busy
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd_addr <= a;
    repeat (2) @(posedge mclk);
    #1 chk(rd_data, exp, "buffer byte");
  endtask : rd
  task automatic wp(input logic v, input int n);
    @(posedge mclk);
    wp_n <= v;
    repeat (n) @(posedge mclk);
    #1;
  endtask : wp
  task automatic prot_cmd(input logic [7:0] last, input logic exp);
    spi_host_model_inst.frame({OP_PROT0, OP_PROT1, OP_PROT2, last});
    chk(prot, exp, "protect status");
  endtask : prot_cmd
  task automatic erase(input logic [64:0] exp);
    spi_host_model_inst.frame({OP_CE[0], OP_CE[1], OP_CE[2], OP_CE[3], 8'h55});
    wait_busy(1'b1);
    chk(op, ARR_CHIP_ERASE, "erase op");
    chk(mask, exp, "erase mask");
  endtask : erase
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 chk(prot, 1'b0, "protect after reset");
    for (int k = 0; k < 2; k++) begin
      spi_host_model_inst.frame({k ? OP_PGM_B2 : OP_PGM_B1, k ? 8'h7f : 8'h00,
        k ? 8'hfe : 8'h16, 8'h0e, k ? 8'hab : 8'haa, 8'hbb, 8'hcc});
      wait_busy(1'b1);
      chk(op, ARR_PAGE_PROG, "program op");
      chk(page, k ? 13'h1fff : 13'h5, "program page");
      chk(sel, k[0], "buffer select");
      wait_busy(1'b0);
      rd(10'h20e, k ? 8'hab : 8'haa);
      rd(10'h20f, 8'hbb);
      rd(10'h000, 8'hcc);
    end
    @(posedge mclk);
    prot_we   <= 1'b1;
    prot_idx  <= 6'h01;
    prot_data <= SEC_PROTECTED;
    @(posedge mclk);
    prot_we <= 1'b0;
    prot_cmd(OP_PROT_EN, 1'b1);
    spi_host_model_inst.frame({OP_PGM_B1, 8'h02, 8'h00, 8'h00, 8'h11});
    chk(busy, 1'b0, "program to guarded sector");
    erase(~65'h404);
    wait_busy(1'b0);
    prot_cmd(OP_PROT_DIS, 1'b0);
    erase(~65'h400);
    wp(1'b0, 15);
    chk(prot, 1'b0, "pin held off during erase");
    wait_busy(1'b0);
    repeat (12) @(posedge mclk);
    #1 chk(prot, 1'b1, "pin after erase");
    prot_cmd(OP_PROT_DIS, 1'b1);
    prot_cmd(OP_PROT_EN, 1'b1);
    wp(1'b1, 15);
    chk(prot, 1'b1, "enable survives pin release");
    prot_cmd(OP_PROT_DIS, 1'b0);
    wp(1'b0, 15);
    chk(prot, 1'b1, "pin asserted");
    @(posedge mclk);
    prot_we   <= 1'b1;
    prot_idx  <= 6'h02;
    prot_data <= SEC_PROTECTED;
    @(posedge mclk);
    prot_we <= 1'b0;
    wp(1'b1, 15);
    chk(prot, 1'b0, "pin released");
    wp(1'b0, 2);
    wp(1'b1, 15);
    chk(prot, 1'b0, "glitch filtered");
    prot_cmd(OP_PROT_EN, 1'b1);
    erase(~65'h404);
    wait_busy(1'b0);
    conclude();
  end
endmodule : serial_flash_erase_program_protect_tb

/* verif/spi_host_model.sv */
module spi_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b1;
  end
  // mode 0, 160 ns serial clock that runs only inside a frame
  task automatic frame(input logic [7:0] bytes[$]);
    cs_n_out = 1'b0;
    #80;
    foreach (bytes[i]) begin
      for (int b = 7; b >= 0; b--) begin
        si_out = bytes[i][b];
        #80 sck_out = 1'b1;
        #80 sck_out = 1'b0;
      end
    end
    #80 cs_n_out = 1'b1;
    si_out = ~si_out;
    #1200;
  endtask : frame
endmodule : spi_host_model
